// ### rtl/dcn_map.svh
`ifndef DCN_MAP_SVH
`define DCN_MAP_SVH

// ----------------------------------------------------------------
// command pin encodings {ras_n, cas_n, we_n} with chip select low
// ----------------------------------------------------------------
`define DCN_CODE_NOP       3'h7
`define DCN_CODE_ACT       3'h3
`define DCN_CODE_READ      3'h5
`define DCN_CODE_WRITE     3'h4
`define DCN_CODE_PRE       3'h2
`define DCN_CODE_REF       3'h1
`define DCN_CODE_MRS       3'h0

// ----------------------------------------------------------------
// mode register selects on the bank pins
// ----------------------------------------------------------------
`define DCN_BA_MR          3'h0
`define DCN_BA_EMR1        3'h1
`define DCN_BA_EMR2        3'h2

// ----------------------------------------------------------------
// field positions on the address pins
// ----------------------------------------------------------------
`define DCN_POS_PRE_ALL    10
`define DCN_POS_HI_TEMP_SR 7

// ----------------------------------------------------------------
// timing counts in link clock cycles, burst length in data beats
// ----------------------------------------------------------------
`define DCN_FC_MIN_CK      2
`define DCN_DLL_LOCK_CK    200
`define DCN_BURST_LEN      4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DCN_RST_HI_TEMP_SR 1'b0
`define DCN_RST_BANKS      8'h00

`endif

// ### rtl/dcn_pkg.sv
package dcn_pkg;

   // decoded command at a link clock edge
   typedef enum logic [2:0] {
      DCN_CMD_NOP   = 3'b000,
      DCN_CMD_ACT   = 3'b001,
      DCN_CMD_READ  = 3'b010,
      DCN_CMD_WRITE = 3'b011,
      DCN_CMD_PRE   = 3'b100,
      DCN_CMD_REF   = 3'b101,
      DCN_CMD_MRS   = 3'b110
   } dcn_cmd_e;

   // power and dll state of the device
   typedef enum logic [2:0] {
      DCN_ST_NORMAL   = 3'b000,
      DCN_ST_PD_PRE   = 3'b001,
      DCN_ST_PD_ACT   = 3'b010,
      DCN_ST_DLL_WAIT = 3'b011,
      DCN_ST_DLL_LOCK = 3'b100
   } dcn_state_e;

endpackage : dcn_pkg

// ### rtl/dcn_sync.sv
// two flip-flop level synchroniser into the destination clock
module dcn_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   // first stage feeds only the second stage
   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta   <= '0;
         o_sync <= '0;
      end else begin
         meta   <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule : dcn_sync

// ### rtl/dcn_core.sv
`include "dcn_map.svh"

// What this block does
// - after dll lock time the device is ready at the new rate
// - chip select low with ras, cas, we high registers a no-operation
// - a no-operation never aborts a burst still in progress
// - chip select high is a deselect, other pins ignored, same as nop
// - extended mode register two bit A7 enables hot self-refresh entry
// - cke low with nop or deselect at an edge enters power-down
// - all banks closed gives precharge power-down, else active power-down
module dcn_core
   import dcn_pkg::*;
#(
   parameter int DLL_LOCK_CK = `DCN_DLL_LOCK_CK,
   parameter int BURST_LEN   = `DCN_BURST_LEN
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_ck,
   input  wire logic        i_cke,
   input  wire logic        i_cs_n,
   input  wire logic        i_ras_n,
   input  wire logic        i_cas_n,
   input  wire logic        i_we_n,
   input  wire logic        i_odt,
   input  wire logic [2:0]  i_ba,
   input  wire logic [12:0] i_addr,
   output logic             o_ready,
   output logic             o_pd_pre,
   output logic             o_pd_act,
   output logic             o_fc_ok,
   output logic             o_burst_busy,
   output logic             o_hi_temp_sr,
   output logic             o_odt_err,
   output logic             o_nop_pulse,
   output dcn_pkg::dcn_state_e o_state
);
   import dcn_pkg::*;

   localparam int BURST_CK = BURST_LEN / 2;
   localparam int LOCK_W   = $clog2(DLL_LOCK_CK + 1);
   localparam int BUR_W    = $clog2(BURST_CK + 1);
   localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(DLL_LOCK_CK - 1);
   localparam logic [BUR_W-1:0]  BUR_LOAD  = BUR_W'(BURST_CK);
   localparam logic [1:0]        FC_MIN    = 2'(`DCN_FC_MIN_CK);

   // -------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------

   // chip select high is a deselect and acts as a nop
   function automatic dcn_cmd_e dcn_decode(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n);
      dcn_cmd_e c;
      c = DCN_CMD_NOP;
      if (!cs_n) begin
         unique case ({ras_n, cas_n, we_n})
            `DCN_CODE_NOP:   c = DCN_CMD_NOP;
            `DCN_CODE_ACT:   c = DCN_CMD_ACT;
            `DCN_CODE_READ:  c = DCN_CMD_READ;
            `DCN_CODE_WRITE: c = DCN_CMD_WRITE;
            `DCN_CODE_PRE:   c = DCN_CMD_PRE;
            `DCN_CODE_REF:   c = DCN_CMD_REF;
            `DCN_CODE_MRS:   c = DCN_CMD_MRS;
            default:         c = DCN_CMD_NOP;      // reserved code acts as nop
         endcase
      end
      return c;
   endfunction : dcn_decode

   // -------------------------------------------------------------
   // link clock domain state
   // -------------------------------------------------------------
   dcn_cmd_e          cmd;
   dcn_state_e        state;
   dcn_state_e        next_state;
   logic [7:0]        banks;
   logic [7:0]        next_banks;
   logic [BUR_W-1:0]  burst_cnt;
   logic [BUR_W-1:0]  next_burst_cnt;
   logic [LOCK_W-1:0] lock_cnt;
   logic [LOCK_W-1:0] next_lock_cnt;
   logic [1:0]        fc_cnt;
   logic [1:0]        next_fc_cnt;
   logic              hi_temp_sr;
   logic              next_hi_temp_sr;
   logic              odt_err;
   logic              next_odt_err;
   logic              nop_tgl;
   logic              next_nop_tgl;
   logic              ready_ck;
   logic              fc_ok_ck;

   assign cmd = dcn_decode(i_cs_n, i_ras_n, i_cas_n, i_we_n);

   // power-down, dll relock and frequency change window
   always_comb begin
      next_state  = state;
      next_fc_cnt = fc_cnt;
      next_lock_cnt = lock_cnt;
      unique case (state)
         DCN_ST_NORMAL, DCN_ST_DLL_WAIT, DCN_ST_DLL_LOCK: begin
            if (!i_cke && cmd == DCN_CMD_NOP) begin
               next_fc_cnt = 2'h0;
               if (banks == `DCN_RST_BANKS) begin
                  next_state = DCN_ST_PD_PRE;
               end else begin
                  next_state = DCN_ST_PD_ACT;
               end
            end else if (state == DCN_ST_DLL_WAIT) begin
               if (cmd == DCN_CMD_MRS && i_ba == `DCN_BA_EMR1) begin
                  next_state    = DCN_ST_DLL_LOCK;
                  next_lock_cnt = '0;
               end
            end else if (state == DCN_ST_DLL_LOCK) begin
               if (lock_cnt == LOCK_LAST) begin
                  next_state = DCN_ST_NORMAL;
               end else begin
                  next_lock_cnt = lock_cnt + LOCK_W'(1);
               end
            end
         end
         DCN_ST_PD_PRE: begin
            if (i_cke) begin
               next_state = DCN_ST_DLL_WAIT;
            end else if (fc_cnt != FC_MIN) begin
               next_fc_cnt = fc_cnt + 2'h1;
            end
         end
         DCN_ST_PD_ACT: begin
            if (i_cke) begin
               next_state = DCN_ST_NORMAL;
            end
         end
         default: begin
            next_state = DCN_ST_NORMAL;
         end
      endcase
   end

   // open banks and burst tracking
   always_comb begin
      next_banks     = banks;
      next_burst_cnt = burst_cnt;
      if (burst_cnt != '0) begin
         next_burst_cnt = burst_cnt - BUR_W'(1);
      end
      if (i_cke) begin
         unique case (cmd)
            DCN_CMD_ACT: begin
               next_banks[i_ba] = 1'b1;
            end
            DCN_CMD_PRE: begin
               if (i_addr[`DCN_POS_PRE_ALL]) begin
                  next_banks = `DCN_RST_BANKS;
               end else begin
                  next_banks[i_ba] = 1'b0;
               end
            end
            DCN_CMD_READ, DCN_CMD_WRITE: begin
               next_burst_cnt = BUR_LOAD;
            end
            DCN_CMD_NOP, DCN_CMD_REF, DCN_CMD_MRS: begin
            end
         endcase
      end
   end

   // mode bits, odt watch and nop event
   always_comb begin
      next_hi_temp_sr = hi_temp_sr;
      next_odt_err    = odt_err;
      next_nop_tgl    = nop_tgl;
      if (i_cke && state == DCN_ST_NORMAL && cmd == DCN_CMD_MRS
          && i_ba == `DCN_BA_EMR2) begin
         next_hi_temp_sr = i_addr[`DCN_POS_HI_TEMP_SR];
      end
      if (i_odt && (state == DCN_ST_PD_PRE || state == DCN_ST_DLL_WAIT
                    || state == DCN_ST_DLL_LOCK)) begin
         next_odt_err = 1'b1;
      end
      if (cmd == DCN_CMD_NOP) begin
         next_nop_tgl = ~nop_tgl;
      end
   end

   always_ff @(posedge i_ck or negedge i_resetn) begin
      if (!i_resetn) begin
         state      <= DCN_ST_NORMAL;
         banks      <= `DCN_RST_BANKS;
         burst_cnt  <= '0;
         lock_cnt   <= '0;
         fc_cnt     <= 2'h0;
         hi_temp_sr <= `DCN_RST_HI_TEMP_SR;
         odt_err    <= 1'b0;
         nop_tgl    <= 1'b0;
      end else begin
         state      <= next_state;
         banks      <= next_banks;
         burst_cnt  <= next_burst_cnt;
         lock_cnt   <= next_lock_cnt;
         fc_cnt     <= next_fc_cnt;
         hi_temp_sr <= next_hi_temp_sr;
         odt_err    <= next_odt_err;
         nop_tgl    <= next_nop_tgl;
      end
   end

   // ready only in normal state; change window needs odt low too
   assign ready_ck = (state == DCN_ST_NORMAL);
   assign fc_ok_ck = (state == DCN_ST_PD_PRE) && (fc_cnt == FC_MIN) && !i_odt;

   // -------------------------------------------------------------
   // crossing into the system clock
   // -------------------------------------------------------------
   logic [6:0] flag_raw;
   logic [6:0] next_flag_raw;
   logic [7:0] st_sync;
   logic [1:0] dll_sync;
   logic       nop_seen;
   logic       nop_last;
   logic       next_nop_last;
   logic       next_nop_pulse;
   dcn_state_e next_o_state;

   // one bit per status, decoded from state, counters and odt before registering
   always_comb begin
      next_flag_raw = {(state == DCN_ST_DLL_LOCK), (state == DCN_ST_DLL_WAIT),
                       (burst_cnt != '0), fc_ok_ck, (state == DCN_ST_PD_ACT),
                       (state == DCN_ST_PD_PRE), ready_ck};
   end

   // flop outputs only, so no decode glitch reaches a synchroniser
   always_ff @(posedge i_ck or negedge i_resetn) begin
      if (!i_resetn) begin
         flag_raw <= 7'h00;
      end else begin
         flag_raw <= next_flag_raw;
      end
   end

   // level status and nop toggle through two flops each
   dcn_sync #(.W(8)) u_sync_st (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  ({nop_tgl, odt_err, hi_temp_sr, flag_raw[4:0]}),
      .o_sync   (st_sync)
   );

   // dll wait and lock flags; the binary state code never crosses
   dcn_sync #(.W(2)) u_sync_state (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  (flag_raw[6:5]),
      .o_sync   (dll_sync)
   );

   assign nop_seen = st_sync[7];

   // toggle edge becomes a one-cycle pulse
   always_comb begin
      next_nop_last  = nop_seen;
      next_nop_pulse = nop_seen ^ nop_last;
   end

   // state view rebuilt from one-hot flags; with none up the last
   // code stands, so crossing skew never shows an illegal code
   always_comb begin
      next_o_state = o_state;
      if (st_sync[0]) begin
         next_o_state = DCN_ST_NORMAL;
      end else if (st_sync[1]) begin
         next_o_state = DCN_ST_PD_PRE;
      end else if (st_sync[2]) begin
         next_o_state = DCN_ST_PD_ACT;
      end else if (dll_sync[1]) begin
         next_o_state = DCN_ST_DLL_LOCK;
      end else if (dll_sync[0]) begin
         next_o_state = DCN_ST_DLL_WAIT;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         nop_last     <= 1'b0;
         o_nop_pulse  <= 1'b0;
         o_ready      <= 1'b0;
         o_pd_pre     <= 1'b0;
         o_pd_act     <= 1'b0;
         o_fc_ok      <= 1'b0;
         o_burst_busy <= 1'b0;
         o_hi_temp_sr <= `DCN_RST_HI_TEMP_SR;
         o_odt_err    <= 1'b0;
         o_state      <= DCN_ST_NORMAL;
      end else begin
         nop_last     <= next_nop_last;
         o_nop_pulse  <= next_nop_pulse;
         o_ready      <= st_sync[0];
         o_pd_pre     <= st_sync[1];
         o_pd_act     <= st_sync[2];
         o_fc_ok      <= st_sync[3];
         o_burst_busy <= st_sync[4];
         o_hi_temp_sr <= st_sync[5];
         o_odt_err    <= st_sync[6];
         o_state      <= next_o_state;
      end
   end
endmodule : dcn_core

// ### dv/dcn_core_sva.sv
module dcn_core_sva #(
   parameter int DLL_LOCK_CK = 200,
   parameter int BURST_LEN   = 4
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic o_ready,
   input wire logic o_pd_pre,
   input wire logic o_pd_act,
   input wire logic o_fc_ok,
   input wire logic o_burst_busy,
   input wire logic o_hi_temp_sr,
   input wire logic o_odt_err,
   input wire logic o_nop_pulse
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // ------------------------------------------------------------
   // power state and status relations
   // ------------------------------------------------------------
   a_pd_exclusive: assert property (!(o_pd_pre && o_pd_act))
      else $error("both power-down flags high");
   a_fc_in_pd: assert property ($rose(o_fc_ok) |-> o_pd_pre)
      else $error("frequency change allowed outside precharge power-down");
   a_odt_err_hold: assert property (o_odt_err |=> o_odt_err)
      else $error("termination error flag cleared without reset");
   a_hot_sr_normal: assert property ($changed(o_hi_temp_sr) |-> o_ready || $past(o_ready))
      else $error("hot self-refresh bit changed outside normal state");
   a_relock_wait: assert property ($fell(o_pd_pre) |-> !o_ready [*2])
      else $error("ready before dll relock");
   a_pre_exit_dll: assert property ($fell(o_pd_pre) |-> !o_pd_act)
      else $error("precharge power-down left into active power-down");
   a_act_exit_ready: assert property ($fell(o_pd_act) |-> ##[0:2] o_ready)
      else $error("active power-down exit not ready");
   a_ready_pd_skew: assert property ((o_ready && (o_pd_pre || o_pd_act)) |=>
                                     !(o_ready && (o_pd_pre || o_pd_act)))
      else $error("ready and power-down high together");

   // main scenarios reached
   c_fc_ok: cover property ($rose(o_fc_ok));
   c_burst: cover property (o_burst_busy);
   c_hot_sr: cover property ($rose(o_hi_temp_sr));
   c_nop: cover property (o_nop_pulse);
endmodule : dcn_core_sva

bind dcn_core dcn_core_sva #(.DLL_LOCK_CK(DLL_LOCK_CK), .BURST_LEN(BURST_LEN)) u_dcn_core_sva (
   .i_clk(i_clk), .i_resetn(i_resetn), .o_ready(o_ready), .o_pd_pre(o_pd_pre),
   .o_pd_act(o_pd_act), .o_fc_ok(o_fc_ok), .o_burst_busy(o_burst_busy),
   .o_hi_temp_sr(o_hi_temp_sr), .o_odt_err(o_odt_err), .o_nop_pulse(o_nop_pulse));

// ### dv/dcn_ctrl_model.sv
`include "dcn_map.svh"

// memory controller side: link clock, cke, odt and command pins
module dcn_ctrl_model (
   output logic        o_ck,
   output logic        o_cke,
   output logic        o_cs_n,
   output logic        o_ras_n,
   output logic        o_cas_n,
   output logic        o_we_n,
   output logic        o_odt,
   output logic [2:0]  o_ba,
   output logic [12:0] o_addr
);
   timeunit 1ns;
   timeprecision 1ps;

   realtime half    = 15.0;
   int      low_cnt = 0;
   realtime refi    = 3900.0;

   // free running link clock, kept running through power-down, where freq_change may set a new rate
   initial o_ck = 1'b0;
   always #(half) o_ck = ~o_ck;

   // idle: nop, cke high, termination off
   initial begin
      {o_cke, o_cs_n, o_odt, o_ba, o_addr} = {1'b1, 1'b0, 1'b0, 3'h0, 13'h0000};
      {o_ras_n, o_cas_n, o_we_n} = `DCN_CODE_NOP;
   end

   // link cycles since cke fell
   always @(posedge o_ck) low_cnt <= o_cke ? 0 : low_cnt + 1;

   // one command at a rising edge, then nop with scrambled address
   task automatic cmd(input logic cs_n, input logic [2:0] code, input logic [2:0] ba,
                      input logic [12:0] addr, input logic cke);
      @(negedge o_ck);
      {o_cs_n, o_ba, o_addr, o_cke} = {cs_n, ba, addr, cke};
      {o_ras_n, o_cas_n, o_we_n} = code;
      @(negedge o_ck);
      {o_cs_n, o_ba, o_addr} = {1'b0, ~ba, ~addr};
      {o_ras_n, o_cas_n, o_we_n} = `DCN_CODE_NOP;
   endtask : cmd

   // one auto-refresh per fixed interval
   task automatic refresh(input int n);
      realtime t0;
      repeat (n) begin
         t0 = $realtime;
         cmd(1'b0, `DCN_CODE_REF, 3'h0, 13'h0000, 1'b1);
         #(refi - ($realtime - t0));
      end
   endtask : refresh

   task automatic set_odt(input logic v);
      @(negedge o_ck);
      o_odt = v;
   endtask : set_odt

   // rate change only in power-down with cke and odt low
   task automatic freq_change(input realtime new_half);
      while (!o_cke && low_cnt < `DCN_FC_MIN_CK) @(negedge o_ck);
      if (!o_cke && !o_odt) half = new_half;
      repeat (4) @(negedge o_ck);
   endtask : freq_change
endmodule : dcn_ctrl_model

// ### dv/tb_top.sv
`include "dcn_map.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int W_RDY = 0, W_PRE = 1, W_ACT = 2, W_FCK = 3, W_BSY = 4;
   localparam int W_HOT = 5, W_ERR = 6, W_LCK = 7;
   logic                i_clk    = 1'b0;
   logic                i_resetn = 1'b0;
   logic                ck, cke, cs_n, ras_n, cas_n, we_n, odt;
   logic [2:0]          ba;
   logic [12:0]         addr;
   logic                o_ready, o_pd_pre, o_pd_act, o_fc_ok, o_burst_busy;
   logic                o_hi_temp_sr, o_odt_err, o_nop_pulse;
   dcn_pkg::dcn_state_e o_state;
   int                  error_cnt = 0;
   int                  tests_run = 0;

   always #50 i_clk = ~i_clk;

   dcn_core #(.DLL_LOCK_CK(8), .BURST_LEN(4)) u_dcn_core (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_ck(ck), .i_cke(cke), .i_cs_n(cs_n),
      .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_odt(odt), .i_ba(ba),
      .i_addr(addr), .o_ready(o_ready), .o_pd_pre(o_pd_pre), .o_pd_act(o_pd_act),
      .o_fc_ok(o_fc_ok), .o_burst_busy(o_burst_busy), .o_hi_temp_sr(o_hi_temp_sr),
      .o_odt_err(o_odt_err), .o_nop_pulse(o_nop_pulse), .o_state(o_state));
   dcn_ctrl_model u_ctl (
      .o_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
      .o_we_n(we_n), .o_odt(odt), .o_ba(ba), .o_addr(addr));

   // ------------------------------------------------------------
   // compare, wait and report helpers
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("errors %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic seen, input logic exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %b expected %b", $time, seen, exp);
      end
   endtask : chk

   function automatic logic pick(input int s);
      case (s)
         W_RDY:   return o_ready;
         W_PRE:   return o_pd_pre;
         W_ACT:   return o_pd_act;
         W_FCK:   return o_fc_ok;
         W_BSY:   return o_burst_busy;
         W_HOT:   return o_hi_temp_sr;
         W_LCK:   return (o_state == dcn_pkg::DCN_ST_DLL_LOCK);
         default: return o_odt_err;
      endcase
   endfunction : pick

   // bounded wait for a status level, giving up ends the run
   task automatic wt(input int s, input logic v);
      int n;
      n = 0;
      while (pick(s) !== v && n < 100) begin
         @(negedge i_clk);
         n++;
      end
      chk(pick(s), v);
      if (n >= 100) stop_test();
   endtask : wt

   task automatic hold(input int s, input logic v, input int n);
      repeat (n) begin
         @(negedge i_clk);
         chk(pick(s), v);
      end
   endtask : hold

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      repeat (20) @(negedge i_clk);
      chk(o_ready, 1'b0);
      i_resetn = 1'b1;
      wt(W_RDY, 1'b1);
   endtask : t_reset

   // deselect and nop carrying an emr2 write pattern give a nop pulse but leave the hot bit low
   task automatic t_nop_desel;
      logic seen;
      seen = 1'b0;
      u_ctl.cmd(1'b1, `DCN_CODE_MRS, `DCN_BA_EMR2, 13'h0080, 1'b1);
      u_ctl.cmd(1'b0, `DCN_CODE_NOP, `DCN_BA_EMR2, 13'h0080, 1'b1);
      repeat (5) begin
         @(negedge i_clk);
         seen = seen | o_nop_pulse;
      end
      chk(seen, 1'b1);
      chk(o_hi_temp_sr, 1'b0);
      u_ctl.cmd(1'b0, `DCN_CODE_MRS, `DCN_BA_EMR2, 13'h0080, 1'b1);
      wt(W_HOT, 1'b1);
      u_ctl.cmd(1'b0, `DCN_CODE_MRS, `DCN_BA_EMR2, 13'h0000, 1'b1);
      wt(W_HOT, 1'b0);
   endtask : t_nop_desel

   // bursts with nops between them keep busy up
   task automatic t_burst;
      logic [2:0] code [2] = '{`DCN_CODE_READ, `DCN_CODE_WRITE};
      for (int k = 0; k < 2; k++) begin
         repeat (4) u_ctl.cmd(1'b0, code[k], 3'h0, 13'h0000, 1'b1);
         wt(W_BSY, 1'b1);
         wt(W_BSY, 1'b0);
      end
      u_ctl.refresh(2);
      chk(o_burst_busy, 1'b0);
      chk(o_ready, 1'b1);
   endtask : t_burst

   task automatic t_pd_act;
      u_ctl.cmd(1'b0, `DCN_CODE_ACT, 3'h1, 13'h0000, 1'b1);
      u_ctl.cmd(1'b0, `DCN_CODE_NOP, 3'h0, 13'h0000, 1'b0);
      wt(W_ACT, 1'b1);
      chk(o_pd_pre, 1'b0);
      chk(o_state == dcn_pkg::DCN_ST_PD_ACT, 1'b1);
      u_ctl.cmd(1'b0, `DCN_CODE_NOP, 3'h0, 13'h0000, 1'b1);
      wt(W_RDY, 1'b1);
      u_ctl.cmd(1'b0, `DCN_CODE_PRE, 3'h0, 13'h0400, 1'b1);
   endtask : t_pd_act

   // rate change in precharge power-down, then dll reset and relock
   task automatic t_freq;
      u_ctl.cmd(1'b1, `DCN_CODE_NOP, 3'h0, 13'h0000, 1'b0);
      wt(W_PRE, 1'b1);
      chk(o_pd_act, 1'b0);
      chk(o_state == dcn_pkg::DCN_ST_PD_PRE, 1'b1);
      wt(W_FCK, 1'b1);
      u_ctl.freq_change(20.0);
      u_ctl.cmd(1'b0, `DCN_CODE_NOP, 3'h0, 13'h0000, 1'b1);
      wt(W_PRE, 1'b0);
      wt(W_FCK, 1'b0);
      hold(W_RDY, 1'b0, 5);
      chk(o_state == dcn_pkg::DCN_ST_DLL_WAIT, 1'b1);
      u_ctl.cmd(1'b0, `DCN_CODE_MRS, `DCN_BA_EMR1, 13'h0000, 1'b1);
      wt(W_LCK, 1'b1);
      u_ctl.cmd(1'b0, `DCN_CODE_MRS, `DCN_BA_MR, 13'h0000, 1'b1);
      wt(W_RDY, 1'b1);
      chk(o_state == dcn_pkg::DCN_ST_NORMAL, 1'b1);
   endtask : t_freq

   // termination raised in power-down, then reset in mid-run
   task automatic t_odt;
      u_ctl.cmd(1'b0, `DCN_CODE_NOP, 3'h0, 13'h0000, 1'b0);
      wt(W_FCK, 1'b1);
      u_ctl.set_odt(1'b1);
      wt(W_FCK, 1'b0);
      wt(W_ERR, 1'b1);
      u_ctl.set_odt(1'b0);
      hold(W_ERR, 1'b1, 3);
      @(negedge i_clk);
      i_resetn = 1'b0;
      u_ctl.cmd(1'b0, `DCN_CODE_NOP, 3'h0, 13'h0000, 1'b1);
      repeat (3) @(negedge i_clk);
      chk(o_odt_err, 1'b0);
      i_resetn = 1'b1;
      wt(W_RDY, 1'b1);
   endtask : t_odt

   initial begin
      t_reset();
      t_nop_desel();
      t_burst();
      t_pd_act();
      t_freq();
      t_odt();
      stop_test();
   end
endmodule : tb_top
